// [rtl/cacp_top.sv]
// counter array: shared counter, high-speed toggle and pwm channels, ahb-lite registers
`timescale 1ns/1ps

// How it works
// - in toggle mode the pin toggles whenever the counter reaches the channel value
// - each toggle match inverts the channel toggle bit and drives it onto the pin
// - toggle bit written one is cleared by the match, left alone it sets again
// - 8-bit pwm uses only the low value byte; the high byte is ignored
// - 8-bit pwm with low byte zero keeps the pin low
// - 8-bit pwm period is 256 counter ticks; source sys, /4, /12 or external
// - clearing the run bit stops pwm and holds the pin low
// - 16-bit pwm uses the whole value; zero keeps the pin low
// - 16-bit pwm period is 65536 counter ticks from the same sources
// - all five channels are configured on their own and may all run pwm
// - the shared counter advances only while the run bit is set
// - idle gate bit one stops the counter while the processor idles
// - each channel has an interrupt enable bit in control register 1
// - control register 2 holds clock select and five flags, reset zero
// - mode field decodes off, three captures, timer, toggle, pwm8, pwm16
// - external source counts each falling edge of the external count pin
module cacp_top
    import cacp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cpu_idle,
    input wire logic external_count_pin,
    output logic [CH_NUM-1:0] channel_pin,
    output logic channel_irq
);

    // ****************************************
    // bus slave
    // ****************************************
    cacp_bus_state_t bus_state_r;
    logic wr_pend_r;
    logic [7:0] wr_idx_r;
    logic [7:0] rd_idx_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic hresp_r;
    logic addr_ok;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;

    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_r && hready;
    assign wr_byte = hwdata[7:0];

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
        hit = (idx == target);
    endfunction

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_r <= CACP_BUS_IDLE;
            hreadyout_r <= 1'b1;
            rd_idx_r <= RST_BYTE;
        end else begin
            case (bus_state_r)
                CACP_BUS_IDLE: begin
                    if (addr_ok && !hwrite) begin
                        bus_state_r <= CACP_BUS_RD_WAIT;
                        hreadyout_r <= 1'b0;
                        rd_idx_r <= haddr[9:2];
                    end
                end
                default: begin
                    bus_state_r <= CACP_BUS_IDLE;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= RST_BYTE;
        end else if (hready) begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r <= haddr[9:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
            if (bus_state_r == CACP_BUS_RD_WAIT) begin
                hrdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;

    // ****************************************
    // control registers
    // ****************************************
    logic run_r;
    logic idle_gate_r;
    logic [CH_NUM-1:0] ien_r;
    cacp_clk_sel_t clk_sel_r;
    logic [CH_NUM-1:0] flag_r;
    logic [CH_NUM-1:0] flag_nxt;
    logic [CH_NUM-1:0] hso_match;
    logic irq_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= 1'b0;
            idle_gate_r <= 1'b0;
            ien_r <= '0;
        end else if (wr_en && hit(wr_idx_r, IDX_RUN_IEN)) begin
            run_r <= wr_byte[RUN_BIT];
            idle_gate_r <= wr_byte[IDLE_GATE_BIT];
            ien_r <= wr_byte[CH_NUM-1:0];
        end
    end

    // a match in the same cycle as a software clear keeps the flag set
    always_comb begin
        flag_nxt = flag_r;
        if (wr_en && hit(wr_idx_r, IDX_CLK_FLAG)) begin
            flag_nxt = wr_byte[CH_NUM-1:0];
        end
        flag_nxt = flag_nxt | hso_match;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_r <= CACP_CLK_SYS;
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
            if (wr_en && hit(wr_idx_r, IDX_CLK_FLAG)) begin
                clk_sel_r <= cacp_clk_sel_t'(wr_byte[CLK_SEL_LSB+:2]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flag_r & ien_r);
        end
    end

    assign channel_irq = irq_r;

    // ****************************************
    // counter clock source and shared counter
    // ****************************************
    logic [3:0] pre_cnt_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic ext_fall;
    logic src_tick;
    logic cnt_tick;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_inc;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_r <= 4'h0;
        end else if (pre_cnt_r == PRE_DIV12_LAST) begin
            pre_cnt_r <= 4'h0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
        end
    end

    // ext_s1_r only feeds ext_s2_r; edge detection uses later stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
            ext_s3_r <= 1'b1;
        end else begin
            ext_s1_r <= external_count_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign ext_fall = ext_s3_r && !ext_s2_r;

    always_comb begin
        case (clk_sel_r)
            CACP_CLK_SYS: src_tick = 1'b1;
            CACP_CLK_DIV4: src_tick = (pre_cnt_r[1:0] == PRE_DIV4_LAST);
            CACP_CLK_DIV12: src_tick = (pre_cnt_r == PRE_DIV12_LAST);
            default: src_tick = ext_fall;
        endcase
    end

    assign cnt_tick = src_tick && run_r && !(idle_gate_r && cpu_idle);
    assign cnt_inc = cnt_r + 16'h0001;

    // a software write to the counter takes priority over counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= RST_WORD;
        end else if (wr_en && hit(wr_idx_r, IDX_CNT_HI)) begin
            cnt_r[15:8] <= wr_byte;
        end else if (wr_en && hit(wr_idx_r, IDX_CNT_LO)) begin
            cnt_r[7:0] <= wr_byte;
        end else if (cnt_tick) begin
            cnt_r <= cnt_inc;
        end
    end

    // ****************************************
    // channels
    // ****************************************
    logic [CNT_W-1:0] value_r [CH_NUM];
    cacp_mode_t mode_r [CH_NUM];
    logic [CH_NUM-1:0] tog_r;
    logic [CH_NUM-1:0] pin_r;

    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
        logic pwm_high;
        logic is_pwm;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                value_r[c] <= RST_WORD;
            end else if (wr_en && hit(wr_idx_r, IDX_VAL_HI[c])) begin
                value_r[c][15:8] <= wr_byte;
            end else if (wr_en && hit(wr_idx_r, IDX_VAL_LO[c])) begin
                value_r[c][7:0] <= wr_byte;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mode_r[c] <= CACP_MODE_OFF;
            end else if (wr_en && hit(wr_idx_r, IDX_MODE[c])) begin
                mode_r[c] <= cacp_mode_t'(wr_byte[MODE_LSB+:3]);
            end
        end

        // match is taken as the counter steps onto the value, so it fires once
        assign hso_match[c] = (mode_r[c] == CACP_MODE_HSO) && cnt_tick && (cnt_inc == value_r[c]);

        // the match wins over a software write in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tog_r[c] <= 1'b0;
            end else if (hso_match[c]) begin
                tog_r[c] <= !tog_r[c];
            end else if (wr_en && hit(wr_idx_r, IDX_MODE[c])) begin
                tog_r[c] <= wr_byte[TOG_BIT];
            end
        end

        always_comb begin
            if (mode_r[c] == CACP_MODE_PWM8) begin
                pwm_high = (cnt_r[7:0] < value_r[c][7:0]);
            end else begin
                pwm_high = (cnt_r < value_r[c]);
            end
        end

        assign is_pwm = (mode_r[c] == CACP_MODE_PWM8) || (mode_r[c] == CACP_MODE_PWM16);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_r[c] <= 1'b0;
            end else if (mode_r[c] == CACP_MODE_HSO) begin
                pin_r[c] <= hso_match[c] ? !tog_r[c] : tog_r[c];
            end else if (is_pwm) begin
                pin_r[c] <= run_r && pwm_high;
            end else begin
                pin_r[c] <= 1'b0;
            end
        end

        // ****************************************
        // channel checks
        // ****************************************
        hso_flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
            hso_match[c] |=> tog_r[c] != $past(tog_r[c]) && channel_pin[c] == tog_r[c])
            else $error("toggle bit or pin did not follow a match");

        pwm_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
            (is_pwm && !run_r) |=> !channel_pin[c])
            else $error("pwm pin not low with counter stopped");

        pwm8_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
            (mode_r[c] == CACP_MODE_PWM8 && value_r[c][7:0] == 8'h00) |=> !channel_pin[c])
            else $error("pwm8 pin high with zero low byte");

        pwm16_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
            (mode_r[c] == CACP_MODE_PWM16 && value_r[c] == RST_WORD) |=> !channel_pin[c])
            else $error("pwm16 pin high with zero value");

        pwm8_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
            (mode_r[c] == CACP_MODE_PWM8 && run_r)
            |=> channel_pin[c] == ($past(cnt_r[7:0]) < $past(value_r[c][7:0])))
            else $error("pwm8 pin does not follow the low byte compare");
    end

    assign channel_pin = pin_r;

    // ****************************************
    // register read mux
    // ****************************************
    always_comb begin
        rd_byte = RST_BYTE;
        if (hit(rd_idx_r, IDX_CNT_HI)) begin
            rd_byte = cnt_r[15:8];
        end else if (hit(rd_idx_r, IDX_CNT_LO)) begin
            rd_byte = cnt_r[7:0];
        end else if (hit(rd_idx_r, IDX_RUN_IEN)) begin
            rd_byte = {run_r, idle_gate_r, 1'b0, ien_r};
        end else if (hit(rd_idx_r, IDX_CLK_FLAG)) begin
            rd_byte = {clk_sel_r, 1'b0, flag_r};
        end else begin
            for (int i = 0; i < CH_NUM; i++) begin
                if (hit(rd_idx_r, IDX_VAL_HI[i])) begin
                    rd_byte = value_r[i][15:8];
                end
                if (hit(rd_idx_r, IDX_VAL_LO[i])) begin
                    rd_byte = value_r[i][7:0];
                end
                if (hit(rd_idx_r, IDX_MODE[i])) begin
                    rd_byte = {3'b000, tog_r[i], 1'b0, mode_r[i]};
                end
            end
        end
    end

    // ****************************************
    // block checks
    // ****************************************
    logic cnt_wr;
    assign cnt_wr = wr_en && (hit(wr_idx_r, IDX_CNT_HI) || hit(wr_idx_r, IDX_CNT_LO));

    sequence div4_gap_s;
        !cnt_tick [*3];
    endsequence

    cnt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!run_r && !cnt_wr) |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    idle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (idle_gate_r && cpu_idle && !cnt_wr) |=> $stable(cnt_r))
        else $error("counter moved while gated by idle");

    div4_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cnt_tick && clk_sel_r == CACP_CLK_DIV4 && run_r && !idle_gate_r)
        ##1 (clk_sel_r == CACP_CLK_DIV4 && run_r && !idle_gate_r) [*3]
        |-> ##1 (clk_sel_r != CACP_CLK_DIV4 || !run_r || idle_gate_r || cnt_tick))
        else $error("divide by four source lost a tick");

    div4_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cnt_tick && clk_sel_r == CACP_CLK_DIV4 && $stable(clk_sel_r)) |=> div4_gap_s or
        (##[0:3] clk_sel_r != CACP_CLK_DIV4))
        else $error("divide by four source ticks too often");

    ext_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_sel_r == CACP_CLK_EXT && run_r && !idle_gate_r && ext_fall) |-> cnt_tick)
        else $error("external falling edge not counted");

    flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|hso_match) |=> ((flag_r & $past(hso_match)) == $past(hso_match)))
        else $error("match did not set its flag");

    irq_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(flag_r & ien_r)) |=> channel_irq)
        else $error("enabled flag gives no interrupt");

endmodule

// [rtl/cacp_pkg.sv]
// constants shared by the counter array compare and pwm block
package cacp_pkg;
    localparam int CH_NUM = 5;
    localparam int CNT_W = 16;
    localparam int DAT_W = 8;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CNT_HI = 8'h9a;
    localparam logic [7:0] IDX_CNT_LO = 8'h9b;
    localparam logic [7:0] IDX_RUN_IEN = 8'ha1;
    localparam logic [7:0] IDX_CLK_FLAG = 8'ha2;
    localparam logic [7:0] IDX_VAL_HI [CH_NUM] = '{8'h9c, 8'h9e, 8'h91, 8'h93, 8'h95};
    localparam logic [7:0] IDX_VAL_LO [CH_NUM] = '{8'h9d, 8'h9f, 8'h92, 8'h94, 8'h96};
    localparam logic [7:0] IDX_MODE [CH_NUM] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};

    // field positions
    localparam int RUN_BIT = 7;
    localparam int IDLE_GATE_BIT = 6;
    localparam int CLK_SEL_LSB = 6;
    localparam int TOG_BIT = 4;
    localparam int MODE_LSB = 0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // clock source divider
    localparam logic [3:0] PRE_DIV12_LAST = 4'hb;
    localparam logic [1:0] PRE_DIV4_LAST = 2'h3;

    typedef enum logic [1:0] {
        CACP_CLK_SYS,
        CACP_CLK_DIV4,
        CACP_CLK_DIV12,
        CACP_CLK_EXT
    } cacp_clk_sel_t;

    typedef enum logic [2:0] {
        CACP_MODE_OFF,
        CACP_MODE_CAP_RISE,
        CACP_MODE_CAP_FALL,
        CACP_MODE_CAP_BOTH,
        CACP_MODE_TIMER,
        CACP_MODE_HSO,
        CACP_MODE_PWM8,
        CACP_MODE_PWM16
    } cacp_mode_t;

    typedef enum logic [1:0] {
        CACP_BUS_IDLE,
        CACP_BUS_RD_WAIT
    } cacp_bus_state_t;
endpackage

// [sim/cacp_pins_model.sv]
// far side model: external count source and channel pin timing monitor
`timescale 1ns/1ps
module cacp_pins_model
    import cacp_pkg::*;
(
    input wire logic hclk,
    input wire logic ext_run,
    output logic external_count_pin,
    input wire logic [CH_NUM-1:0] channel_pin,
    output logic [31:0] hi_len [CH_NUM],
    output logic [31:0] per_len [CH_NUM],
    output logic [31:0] rise_cnt [CH_NUM]
);
    logic [2:0] ph;
    logic [31:0] age [CH_NUM];
    logic [CH_NUM-1:0] pin_d;

    initial begin
        ph = 3'h0;
        external_count_pin = 1'b1;
        pin_d = '0;
        for (int i = 0; i < CH_NUM; i++) begin
            hi_len[i] = 0;
            per_len[i] = 0;
            rise_cnt[i] = 0;
            age[i] = 0;
        end
    end

    // period of eight clocks, the fastest source the counter is specified for
    // source stands still high while unused so no stray falling edges appear
    always @(posedge hclk) begin
        ph <= ph + 3'h1;
        external_count_pin <= ext_run ? ph[2] : 1'b1;
        pin_d <= channel_pin;
        for (int i = 0; i < CH_NUM; i++) begin
            age[i] <= age[i] + 1;
            if (channel_pin[i] && !pin_d[i]) begin
                per_len[i] <= age[i];
                age[i] <= 1;
                rise_cnt[i] <= rise_cnt[i] + 1;
            end
            if (!channel_pin[i] && pin_d[i]) begin
                hi_len[i] <= age[i];
            end
        end
    end
endmodule

// [sim/counter_array_compare_pwm_tb_top.sv]
// self-checking testbench of the counter array compare and pwm block
`timescale 1ns/1ps
module counter_array_compare_pwm_tb_top;
    import cacp_pkg::*;
    logic hclk, hsel = 0, hwrite = 0, cpu_idle = 0, ext_run = 0, hresetn = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, channel_irq, external_count_pin;
    logic [CH_NUM-1:0] channel_pin;
    logic [31:0] hi_len [CH_NUM], per_len [CH_NUM], rise_cnt [CH_NUM];
    int n_fail = 0, check_count = 0;
    assign hready = hreadyout;

    cacp_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cpu_idle(cpu_idle), .external_count_pin(external_count_pin),
        .channel_pin(channel_pin), .channel_irq(channel_irq));
    cacp_pins_model i_pins (.hclk(hclk), .ext_run(ext_run), .external_count_pin(external_count_pin),
        .channel_pin(channel_pin), .hi_len(hi_len), .per_len(per_len), .rise_cnt(rise_cnt));

    initial begin
        hclk = 0;
        forever #20 hclk = ~hclk;
    end

    // ****************************************
    // compare and bus tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_byte(string nm, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bit(string nm, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chk_len(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) chk_bit("hreadyout", 1'b1, hreadyout);
    endtask
    // non-pipelined single word transfer; read data taken at the ready edge
    task automatic bus(logic w, logic [7:0] idx, logic [7:0] wd, output logic [7:0] rd);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata[7:0];
        chk_bit("hresp", 1'b0, hresp);
    endtask
    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic chk_reg(string nm, logic [7:0] idx, logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk_byte(nm, exp, x);
    endtask
    task automatic wait_rise(int ch, int k, int lim);
        logic [31:0] s;
        int n;
        s = rise_cnt[ch];
        n = 0;
        while (rise_cnt[ch] < s + k && n < lim) begin
            @(posedge hclk);
            n++;
        end
        if (n >= lim) chk_len("pwm rises", s + k, rise_cnt[ch]);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [7:0] a, b, lo;
        int dv [4];
        dv = '{1, 4, 12, 8};
        v = $urandom(37389);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < CH_NUM; i++) begin
            chk_reg("value high", IDX_VAL_HI[i], RST_BYTE);
            chk_reg("value low", IDX_VAL_LO[i], RST_BYTE);
            chk_reg("mode", IDX_MODE[i], RST_BYTE);
        end
        chk_reg("counter high", IDX_CNT_HI, RST_BYTE);
        chk_reg("counter low", IDX_CNT_LO, RST_BYTE);
        chk_reg("run enable", IDX_RUN_IEN, RST_BYTE);
        chk_reg("clock flags", IDX_CLK_FLAG, RST_BYTE);
        // random register traffic with the counter stopped
        for (int i = 0; i < CH_NUM; i++) begin
            v = $urandom;
            wr(IDX_VAL_HI[i], v[7:0]);
            wr(IDX_VAL_LO[i], v[15:8]);
            wr(IDX_MODE[i], v[23:16]);
            chk_reg("value high", IDX_VAL_HI[i], v[7:0]);
            chk_reg("value low", IDX_VAL_LO[i], v[15:8]);
            chk_reg("mode", IDX_MODE[i], v[23:16] & 8'h17);
            wr(IDX_MODE[i], 8'h00);
        end
        chk_byte("pins stopped", 8'h00, {3'h0, channel_pin});
        v = $urandom;
        wr(IDX_CLK_FLAG, v[7:0]);
        chk_reg("clock flags", IDX_CLK_FLAG, v[7:0] & 8'hdf);
        chk_bit("irq masked", 1'b0, channel_irq);
        wr(IDX_RUN_IEN, 8'h1f);
        repeat (2) @(posedge hclk);
        chk_bit("irq enabled", |v[4:0], channel_irq);
        wr(IDX_CLK_FLAG, 8'h00);
        wr(IDX_RUN_IEN, 8'h00);
        chk_bit("irq cleared", 1'b0, channel_irq);
        wr(8'h90, 8'hff);
        chk_reg("unmapped", 8'h90, 8'h00);
        // run control and idle gating
        wr(IDX_RUN_IEN, 8'h80);
        repeat (20) @(posedge hclk);
        wr(IDX_RUN_IEN, 8'h00);
        bus(1'b0, IDX_CNT_LO, 8'h00, a);
        chk_bit("counter ran", 1'b1, a != 8'h00);
        repeat (10) @(posedge hclk);
        chk_reg("counter stopped", IDX_CNT_LO, a);
        cpu_idle <= 1'b1;
        wr(IDX_RUN_IEN, 8'hc0);
        repeat (10) @(posedge hclk);
        chk_reg("counter gated", IDX_CNT_LO, a);
        wr(IDX_RUN_IEN, 8'h80);
        bus(1'b0, IDX_CNT_LO, 8'h00, a);
        repeat (10) @(posedge hclk);
        bus(1'b0, IDX_CNT_LO, 8'h00, b);
        chk_bit("counter in idle", 1'b1, a != b);
        wr(IDX_RUN_IEN, 8'h00);
        cpu_idle <= 1'b0;
        // high-speed output on channel 1
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_VAL_HI[1], 8'h00);
        wr(IDX_VAL_LO[1], 8'h40);
        wr(IDX_MODE[1], 8'h05);
        wr(IDX_MODE[3], 8'h14);
        wr(IDX_CLK_FLAG, 8'h00);
        wr(IDX_RUN_IEN, 8'h80);
        repeat (80) @(posedge hclk);
        chk_bit("toggle pin", 1'b1, channel_pin[1]);
        chk_bit("timer mode pin", 1'b0, channel_pin[3]);
        chk_reg("toggle bit", IDX_MODE[1], 8'h15);
        chk_reg("match flag", IDX_CLK_FLAG, 8'h02);
        chk_bit("irq disabled", 1'b0, channel_irq);
        wr(IDX_RUN_IEN, 8'h82);
        repeat (2) @(posedge hclk);
        chk_bit("irq raised", 1'b1, channel_irq);
        wr(IDX_CLK_FLAG, 8'h00);
        repeat (2) @(posedge hclk);
        chk_bit("irq after clear", 1'b0, channel_irq);
        wr(IDX_MODE[1], 8'h15);
        wr(IDX_CNT_LO, 8'h00);
        repeat (80) @(posedge hclk);
        chk_bit("toggle pin low", 1'b0, channel_pin[1]);
        chk_reg("toggle cleared", IDX_MODE[1], 8'h05);
        wr(IDX_CNT_LO, 8'h00);
        repeat (80) @(posedge hclk);
        chk_bit("toggle pin high", 1'b1, channel_pin[1]);
        wr(IDX_RUN_IEN, 8'h00);
        wr(IDX_MODE[1], 8'h00);
        // 8-bit pwm from each clock source, random width and ignored high byte
        for (int s = 0; s < 4; s++) begin
            v = $urandom;
            lo = {1'b0, v[6:0]} | 8'h01;
            wr(IDX_VAL_HI[0], v[15:8]);
            wr(IDX_VAL_LO[0], lo);
            wr(IDX_MODE[0], 8'h06);
            wr(IDX_CLK_FLAG, 8'(s << 6));
            ext_run <= (s == 3);
            wr(IDX_RUN_IEN, 8'h80);
            wait_rise(0, 3, 1024 * dv[s]);
            chk_len("pwm8 period", 256 * dv[s], per_len[0]);
            chk_len("pwm8 high", lo * dv[s], hi_len[0]);
            wr(IDX_RUN_IEN, 8'h00);
            repeat (3) @(posedge hclk);
            chk_bit("pwm8 run off", 1'b0, channel_pin[0]);
        end
        ext_run <= 1'b0;
        // all channels at once, channel 0 at zero width
        wr(IDX_CLK_FLAG, 8'h00);
        for (int i = 0; i < CH_NUM; i++) begin
            wr(IDX_VAL_LO[i], 8'(i * 40));
            wr(IDX_MODE[i], 8'h06);
        end
        a = rise_cnt[0][7:0];
        wr(IDX_RUN_IEN, 8'h80);
        wait_rise(4, 3, 2000);
        for (int i = 1; i < CH_NUM; i++) chk_len("pwm8 channel high", i * 40, hi_len[i]);
        chk_len("zero width rises", a, rise_cnt[0][7:0]);
        wr(IDX_RUN_IEN, 8'h00);
        repeat (3) @(posedge hclk);
        chk_byte("pins run off", 8'h00, {3'h0, channel_pin});
        // 16-bit pwm with a zero low byte, counter preset just below wrap
        wr(IDX_VAL_HI[2], 8'h01);
        wr(IDX_VAL_LO[2], 8'h00);
        wr(IDX_MODE[2], 8'h07);
        wr(IDX_CNT_HI, 8'hff);
        wr(IDX_CNT_LO, 8'hf0);
        wr(IDX_RUN_IEN, 8'h80);
        wait_rise(2, 2, 70000);
        chk_len("pwm16 period", 65536, per_len[2]);
        chk_len("pwm16 high", 256, hi_len[2]);
        wr(IDX_VAL_HI[2], 8'h00);
        repeat (300) @(posedge hclk);
        chk_bit("pwm16 zero", 1'b0, channel_pin[2]);
        wr(IDX_RUN_IEN, 8'h00);
        results();
    end

    // worst case run is about 87000 cycles, mostly the 16-bit period
    initial begin
        repeat (95000) @(posedge hclk);
        n_fail++;
        $display("ERROR watchdog expected done seen timeout");
        results();
    end
endmodule
